// ===== verif/las_plc_model.sv
// plant controller model driving its three request levels
`timescale 1ns/10ps
module las_plc_model (
	// clock
	input wire logic pclk,
	// controller levels
	output logic cycle_start_input,
	output logic cycle_stop_input,
	output logic first_label_request
);
	initial begin
		cycle_start_input = 1'b0;
		cycle_stop_input = 1'b0;
		first_label_request = 1'b0;
	end
	task automatic send(input logic [2:0] m, input int n);
		@(posedge pclk);
		{cycle_start_input, cycle_stop_input, first_label_request} <= m;
		repeat (n) @(posedge pclk);
		{cycle_start_input, cycle_stop_input, first_label_request} <= 3'b0;
	endtask
endmodule // las_plc_model

// ===== verif/las_seq_assertions.sv
// port checker for the label applicator sequencer
`timescale 1ns/10ps
module las_seq_chk import las_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic printer_error,
	input wire logic printer_fault_output,
	input wire logic label_done,
	input wire logic position_sensor,
	input wire logic print_go,
	input wire logic vacuum_on,
	input wire logic air_on,
	input wire logic cylinder_down
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_fault_lag: assert property (printer_fault_output ==
		$past(printer_error, 3)) else $error("fault lag wrong");
	chk_air_vacuum: assert property (air_on |-> vacuum_on)
		else $error("air without vacuum");
	chk_go_pulse: assert property (print_go |=> !print_go)
		else $error("print pulse too long");
	chk_go_vac: assert property (print_go |->
		##[0:1] (vacuum_on && air_on)) else $error("no vacuum on print");
	chk_air_pick: assert property (air_on && label_done |->
		##[0:6] !air_on) else $error("air kept after pick");
	chk_place_up: assert property (cylinder_down && position_sensor |->
		##[0:8] !cylinder_down) else $error("pad not raised");
	chk_down_air: assert property (cylinder_down |-> !air_on)
		else $error("air on while lowered");
	chk_apb_wait: assert property (psel && !penable |=> pready)
		else $error("apb answer late");
	chk_apb_err: assert property (psel && penable && pready &&
		(paddr > 8'h18 || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("bad address accepted");
endmodule // las_seq_chk

// ===== verif/tb_top.sv
// testbench for the label applicator sequencer
`timescale 1ns/10ps
module tb_top import las_pkg::*;;
	typedef struct {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} las_row_s;
	las_row_s rows [12] = '{
		'{0, REG_LOCKOUT, 0, 32'h0ee6_b280, 0},
		'{0, REG_DELAY, 0, 32'h0ee6_b280, 0},
		'{1, REG_LOCKOUT, 10, 0, 0},
		'{1, REG_DELAY, 10, 0, 0},
		'{1, REG_PEEL_CFG, 5, 0, 0},
		'{1, REG_PEEL_JOB, 3, 0, 0},
		'{0, REG_PEEL_EFF, 0, 8, 0},
		'{0, REG_DELAY, 0, 10, 0},
		'{1, REG_PEEL_EFF, 1, 0, 0},
		'{0, REG_PEEL_EFF, 0, 8, 0},
		'{0, 8'h1c, 0, 0, 1},
		'{1, 8'h1e, 0, 0, 1}};
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cycle_start_input, cycle_stop_input, first_label_request;
	logic printer_fault_output, feed_key, predispense_key, printer_error;
	logic position_sensor, pad_home, print_go, vacuum_on, er;
	logic air_on, cylinder_down;
	logic label_done = 1'b0;
	logic [PEEL_W-1:0] peel_position;
	logic [7:0] dsh = '0;
	int lcnt = 0, cyc = 0, n_go = 0, err_count = 0, n_compared = 0;
	int go0 = 0;
	las_seq dut_u (.*);
	las_plc_model plc_u (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// pad travel and label pick-up of the mechanics
	assign position_sensor = dsh[7] & cylinder_down;
	assign pad_home = ~dsh[7] & ~cylinder_down;
	always @(posedge pclk) begin
		dsh <= {dsh[6:0], cylinder_down};
		cyc <= cyc + 1;
		if (print_go) n_go++;
		if (print_go || feed_key) begin
			lcnt <= 8;
			label_done <= 1'b0;
		end else if (lcnt != 0 && !printer_error) begin
			lcnt <= lcnt - 1;
			label_done <= (lcnt == 1);
		end else begin
			label_done <= 1'b0;
		end
		if (cyc == 8000) begin
			err_count++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	function automatic logic out_of(input int k);
		case (k)
			0: return print_go;
			1: return vacuum_on;
			2: return air_on;
			3: return cylinder_down;
			default: return printer_fault_output;
		endcase
	endfunction
	// wait up to n cycles for output k at v, hit must equal w
	task automatic see(input int k, input logic v, input int n, input logic w);
		logic hit;
		hit = 1'b0;
		for (int j = 0; j < n && !hit; j++) begin
			@(posedge pclk);
			hit = (out_of(k) === v);
		end
		chk(hit, w);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic key(input int k, input int n);
		predispense_key <= 1'b1;
		see(k, 1'b1, n, 1'b1);
		predispense_key <= 1'b0;
	endtask
	task automatic test_done;
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{feed_key, predispense_key, printer_error} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w && !rows[i].e) chk(rd, rows[i].x);
			chk(er, rows[i].e);
		end
		chk(peel_position, 16'h8);
		feed_key <= 1'b1;
		see(2, 1'b1, 8, 1'b1);
		chk(vacuum_on, 1'b1);
		feed_key <= 1'b0;
		see(2, 1'b0, 30, 1'b1);
		chk(vacuum_on, 1'b1);
		key(3, 8);
		see(1, 1'b0, 30, 1'b1);
		see(3, 1'b0, 8, 1'b1);
		repeat (20) @(posedge pclk);
		apb(1'b1, REG_CTRL, 32'h1);
		key(0, 10);
		see(2, 1'b0, 30, 1'b1);
		key(3, 10);
		see(3, 1'b0, 40, 1'b1);
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (20) @(posedge pclk);
		plc_u.send(3'b001, 4);
		see(0, 1'b1, 40, 1'b0);
		plc_u.send(3'b100, 4);
		see(0, 1'b1, 4, 1'b0);
		see(0, 1'b1, 30, 1'b1);
		see(2, 1'b0, 30, 1'b1);
		see(3, 1'b1, 10, 1'b1);
		see(3, 1'b0, 30, 1'b1);
		chk(vacuum_on, 1'b0);
		repeat (20) @(posedge pclk);
		plc_u.send(3'b100, 2);
		see(0, 1'b1, 30, 1'b1);
		printer_error <= 1'b1;
		see(4, 1'b1, 5, 1'b1);
		printer_error <= 1'b0;
		see(0, 1'b1, 30, 1'b1);
		see(3, 1'b1, 40, 1'b1);
		see(3, 1'b0, 40, 1'b1);
		repeat (20) @(posedge pclk);
		apb(1'b1, REG_CTRL, 32'h2);
		plc_u.send(3'b001, 4);
		see(0, 1'b1, 30, 1'b1);
		see(2, 1'b0, 30, 1'b1);
		go0 = n_go;
		plc_u.send(3'b100, 4);
		see(3, 1'b1, 30, 1'b1);
		chk(n_go - go0, 0);
		see(0, 1'b1, 60, 1'b1);
		see(2, 1'b0, 30, 1'b1);
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (20) @(posedge pclk);
		plc_u.send(3'b100, 4);
		see(0, 1'b1, 30, 1'b1);
		plc_u.send(3'b010, 4);
		see(2, 1'b0, 20, 1'b1);
		see(3, 1'b1, 20, 1'b0);
		apb(1'b0, REG_STATUS, 0);
		chk(rd[ST_HOST_STOP], 1'b0);
		chk(rd[ST_STOPPED], 1'b1);
		plc_u.send(3'b100, 4);
		see(0, 1'b1, 40, 1'b0);
		apb(1'b1, REG_CTRL, 32'h4);
		repeat (20) @(posedge pclk);
		plc_u.send(3'b100, 4);
		see(3, 1'b1, 60, 1'b1);
		plc_u.send(3'b010, 4);
		see(3, 1'b0, 10, 1'b1);
		apb(1'b0, REG_STATUS, 0);
		chk(rd[ST_HOST_STOP], 1'b1);
		apb(1'b1, REG_CTRL, 32'h0000_0004);
		apb(1'b1, REG_LOCKOUT, 32'h0000_03e8);
		repeat (20) @(posedge pclk);
		plc_u.send(3'b100, 4);
		see(0, 1'b1, 30, 1'b1);
		see(3, 1'b1, 40, 1'b1);
		see(3, 1'b0, 40, 1'b1);
		repeat (20) @(posedge pclk);
		plc_u.send(3'b100, 4);
		see(0, 1'b1, 40, 1'b0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({vacuum_on, air_on, cylinder_down, print_go}, 4'h0);
		chk(peel_position, 16'h0000);
		presetn <= 1'b1;
		apb(1'b0, REG_LOCKOUT, 0);
		chk(rd, START_LOCKOUT_CYC);
		apb(1'b0, REG_DELAY, 0);
		chk(rd, START_DELAY_CYC);
		apb(1'b0, REG_STATUS, 0);
		chk(rd[ST_STATE +: 8], LAS_IDLE);
		chk(rd[ST_STOPPED], 1'b0);
		test_done;
	end
endmodule // tb_top
bind las_seq las_seq_chk chk_u (.*);

// ===== verilog/las_pkg.sv
// constants and types shared by the label applicator sequencer
package las_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// timing figures in milliseconds, then derived cycle counts
	localparam int unsigned START_LOCKOUT_MS = 2500;
	localparam int unsigned START_DELAY_MS = 2500;
	localparam int unsigned MOVE_TIMEOUT_MS = 2000;
	localparam int unsigned START_LOCKOUT_CYC = START_LOCKOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned START_DELAY_CYC = START_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned MOVE_TIMEOUT_CYC = MOVE_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W = 32;
	localparam int unsigned PEEL_W = 16;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PEEL_CFG = 8'h08;
	localparam logic [7:0] REG_PEEL_JOB = 8'h0c;
	localparam logic [7:0] REG_PEEL_EFF = 8'h10;
	localparam logic [7:0] REG_LOCKOUT = 8'h14;
	localparam logic [7:0] REG_DELAY = 8'h18;
	// ctrl fields
	localparam int unsigned CTRL_JOB = 0;
	localparam int unsigned CTRL_APPLY_FIRST = 1;
	localparam int unsigned CTRL_CLR_ERR = 2;
	// status fields
	localparam int unsigned ST_HOST_STOP = 0;
	localparam int unsigned ST_MOVE_ERR = 1;
	localparam int unsigned ST_STOPPED = 2;
	localparam int unsigned ST_HOLD = 3;
	localparam int unsigned ST_FAULT = 4;
	localparam int unsigned ST_STATE = 8;

	typedef enum logic [7:0] {
		LAS_IDLE = 8'b0000_0001,
		LAS_WAIT = 8'b0000_0010,
		LAS_PRINT = 8'b0000_0100,
		LAS_PICK = 8'b0000_1000,
		LAS_DOWN = 8'b0001_0000,
		LAS_PLACE = 8'b0010_0000,
		LAS_UP = 8'b0100_0000,
		LAS_HALT = 8'b1000_0000
	} las_state_e;
endpackage

// ===== verilog/las_seq.sv
// label applicator sequencer with apb registers
// Overview of operation
// - no job: feed key feeds, vacuum and air
// - label picked: air off, vacuum kept
// - test mode key: lower, place, return
// - with job, key alternates half cycles
// - first half: print one, air until pick
// - second half: lower, sense, drop, raise
// - peel is configured plus job value
// - stop still finishes print and pick
// - stop aborts process, pad returns home
// - after stop ignore controller inputs
// - stop during lower, place or raise flags host stop
// - apply-first: start lowers pad first
// - print-first mode ignores first-label
// - printer fault opens fault output
// - after fault clears, reprint last label
// - starts inside lockout are ignored
// - start delay before process begins
// - cylinder timeout aborts with error
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module las_seq import las_pkg::*; (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// plant controller pins
	input wire logic cycle_start_input,
	input wire logic cycle_stop_input,
	input wire logic first_label_request,
	output logic printer_fault_output,
	// local keys, printer status and pad sensor pins
	input wire logic feed_key,
	input wire logic predispense_key,
	input wire logic printer_error,
	input wire logic label_done,
	input wire logic position_sensor,
	input wire logic pad_home,
	// actuators
	output logic print_go,
	output logic vacuum_on,
	output logic air_on,
	output logic cylinder_down,
	output logic [PEEL_W-1:0] peel_position
);
	typedef struct packed {
		las_state_e st;
		logic job;
		logic apply_first;
		logic [PEEL_W-1:0] peel_cfg;
		logic [PEEL_W-1:0] peel_job;
		logic [TMR_W-1:0] lockout;
		logic [TMR_W-1:0] delay;
		logic half;
		logic hold;
		logic stopped;
		logic host_stop;
		logic move_err;
		logic reprint;
		logic print_cycle;
		logic test;
		logic [3:0] prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic fault;
		logic print_go;
		logic vacuum;
		logic air;
		logic down;
		logic [PEEL_W-1:0] peel;
	} las_s;

	las_s r, next_r;
	logic s_start, s_stop, s_first, s_feed, s_key, s_err, s_done;
	logic s_pos, s_home;
	logic lock_ld, dly_ld, mv_ld, lock_busy, dly_busy, mv_busy;

	// every controller, key, printer and sensor pin is brought onto pclk before use; apb pins are used directly
	// sensor synchronisers
	las_sync #(.W(9)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d({cycle_start_input, cycle_stop_input, first_label_request,
			feed_key, predispense_key, printer_error, label_done,
			position_sensor, pad_home}),
		.q({s_start, s_stop, s_first, s_feed, s_key, s_err, s_done,
			s_pos, s_home})
	);

	// lockout and delay reload from their registers on an accepted start
	las_timer u_lock (.pclk(pclk), .presetn(presetn), .ce(ce),
		.load(lock_ld), .value(r.lockout), .busy(lock_busy));
	las_timer u_dly (.pclk(pclk), .presetn(presetn), .ce(ce),
		.load(dly_ld), .value(r.delay), .busy(dly_busy));
	// fixed move timeout so a stuck cylinder cannot hang the pad
	las_timer u_mv (.pclk(pclk), .presetn(presetn), .ce(ce),
		.load(mv_ld), .value(MOVE_TIMEOUT_CYC), .busy(mv_busy));

	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	always_comb begin
		logic wr, rd, st_rise, key_rise, feed_rise, first_rise;
		wr = 1'b0;
		rd = 1'b0;
		st_rise = 1'b0;
		key_rise = 1'b0;
		feed_rise = 1'b0;
		first_rise = 1'b0;
		next_r = r;
		lock_ld = 1'b0;
		dly_ld = 1'b0;
		mv_ld = 1'b0;
		next_r.prev = {s_start, s_key, s_feed, s_first};
		st_rise = rise(s_start, r.prev[3]);
		key_rise = rise(s_key, r.prev[2]);
		feed_rise = rise(s_feed, r.prev[1]);
		first_rise = rise(s_first, r.prev[0]);

		// apb: zero wait states, answer in the access cycle
		wr = psel & penable & pwrite;
		rd = psel & ~penable & ~pwrite;
		next_r.pready = psel & ~penable;
		next_r.pslverr = 1'b0;
		if (psel && !penable) begin
			next_r.pslverr = (paddr[1:0] != 2'b00) || (paddr > REG_DELAY);
		end
		if (rd) begin
			case (paddr)
			REG_CTRL:
				next_r.prdata = {30'h0, r.apply_first, r.job};
			REG_STATUS:
				next_r.prdata = {16'h0, r.st, 3'h0, r.fault, r.hold,
					r.stopped, r.move_err, r.host_stop};
			REG_PEEL_CFG:
				next_r.prdata = {16'h0, r.peel_cfg};
			REG_PEEL_JOB:
				next_r.prdata = {16'h0, r.peel_job};
			REG_PEEL_EFF:
				next_r.prdata = {16'h0, r.peel};
			REG_LOCKOUT:
				next_r.prdata = r.lockout;
			REG_DELAY:
				next_r.prdata = r.delay;
			default:
				next_r.prdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (paddr)
			REG_CTRL: begin
				next_r.job = pwdata[CTRL_JOB];
				next_r.apply_first = pwdata[CTRL_APPLY_FIRST];
				if (pwdata[CTRL_CLR_ERR]) begin
					next_r.host_stop = 1'b0;
					next_r.move_err = 1'b0;
					next_r.stopped = 1'b0;
				end
			end
			REG_PEEL_CFG:
				next_r.peel_cfg = pwdata[PEEL_W-1:0];
			REG_PEEL_JOB:
				next_r.peel_job = pwdata[PEEL_W-1:0];
			REG_LOCKOUT:
				next_r.lockout = pwdata;
			REG_DELAY:
				next_r.delay = pwdata;
			default: begin
			end
			endcase
		end

		next_r.peel = PEEL_W'(r.peel_cfg + r.peel_job);
		next_r.fault = s_err;
		if (s_err && (r.st == LAS_PRINT))
			next_r.reprint = 1'b1;

		case (r.st)
		LAS_IDLE: begin
			next_r.print_go = 1'b0;
			if (key_rise && !r.job && r.hold) begin
				next_r.test = 1'b1;
				next_r.st = LAS_DOWN;
				mv_ld = 1'b1;
			end else if ((feed_rise || key_rise) && !r.job && !r.hold) begin
				next_r.test = 1'b1;
				next_r.st = LAS_PRINT;
			end else if (key_rise && r.job) begin
				next_r.test = 1'b1;
				next_r.half = ~r.half;
				next_r.st = r.half ? LAS_DOWN : LAS_PRINT;
				mv_ld = r.half;
			end else if (first_rise && r.apply_first && !r.hold
				&& !r.stopped) begin
				next_r.test = 1'b0;
				next_r.st = LAS_PRINT;
			end else if (st_rise && !lock_busy && !r.stopped) begin
				lock_ld = 1'b1;
				dly_ld = 1'b1;
				next_r.test = 1'b0;
				next_r.st = LAS_WAIT;
			end
		end
		LAS_WAIT: begin
			if (!dly_busy) begin
				if (r.apply_first) begin
					next_r.st = LAS_DOWN;
					mv_ld = 1'b1;
				end else
					next_r.st = LAS_PRINT;
			end
		end
		LAS_PRINT: begin
			if (!s_err) begin
				next_r.print_go = 1'b1;
				next_r.vacuum = 1'b1;
				next_r.air = 1'b1;
				next_r.print_cycle = 1'b1;
				next_r.reprint = 1'b0;
				next_r.st = LAS_PICK;
			end
		end
		LAS_PICK: begin
			next_r.print_go = 1'b0;
			// fault during pick-up: print the label again
			if (s_err) begin
				next_r.reprint = 1'b1;
				next_r.st = LAS_PRINT;
			end else if (s_done) begin
				next_r.air = 1'b0;
				next_r.hold = 1'b1;
				next_r.print_cycle = 1'b0;
				next_r.st = (r.apply_first || r.test || r.stopped)
					? LAS_IDLE : LAS_DOWN;
				mv_ld = !(r.apply_first || r.test || r.stopped);
			end
		end
		LAS_DOWN: begin
			next_r.down = 1'b1;
			if (s_pos) begin
				next_r.st = LAS_PLACE;
			end else if (!mv_busy && !mv_ld) begin
				next_r.move_err = 1'b1;
				next_r.down = 1'b0;
				next_r.st = LAS_HALT;
				mv_ld = 1'b1;
			end
		end
		LAS_PLACE: begin
			next_r.vacuum = 1'b0;
			next_r.hold = 1'b0;
			next_r.down = 1'b0;
			next_r.st = LAS_UP;
			mv_ld = 1'b1;
		end
		LAS_UP: begin
			if (s_home) begin
				next_r.st = (r.apply_first && !r.test) ? LAS_PRINT
					: LAS_IDLE;
			end else if (!mv_busy && !mv_ld) begin
				next_r.move_err = 1'b1;
				next_r.st = LAS_IDLE;
			end
		end
		LAS_HALT: begin
			next_r.down = 1'b0;
			if (s_home || (!mv_busy && !mv_ld))
				next_r.st = LAS_IDLE;
		end
		default:
			next_r.st = LAS_IDLE;
		endcase

		// keys run test operations, so stop leaves those alone
		// stop waits out print and pick
		if (s_stop && !r.stopped && !r.test) begin
			next_r.stopped = 1'b1;
			if (r.st == LAS_DOWN || r.st == LAS_PLACE || r.st == LAS_UP)
				next_r.host_stop = 1'b1;
			if (r.st == LAS_WAIT || r.st == LAS_DOWN) begin
				next_r.down = 1'b0;
				next_r.st = LAS_HALT;
				mv_ld = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= LAS_IDLE;
			// slow defaults until software shortens the timing
			r.lockout <= START_LOCKOUT_CYC;
			r.delay <= START_DELAY_CYC;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign printer_fault_output = r.fault;
	assign print_go = r.print_go;
	assign vacuum_on = r.vacuum;
	assign air_on = r.air;
	assign cylinder_down = r.down;
	assign peel_position = r.peel;
endmodule // las_seq

// ===== verilog/las_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module las_sync import las_pkg::*; #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // las_sync

// ===== verilog/las_timer.sv
// down counter with load and expiry flag
`timescale 1ns/10ps
module las_timer import las_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control
	input wire logic load,
	input wire logic [TMR_W-1:0] value,
	output logic busy
);
	logic [TMR_W-1:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (ce) begin
			if (load)
				cnt <= value;
			else if (cnt != '0)
				cnt <= cnt - 1'b1;
		end
	end

	assign busy = (cnt != '0);
endmodule // las_timer
